// ---- src/srmq_device.sv ----
`timescale 1ns/1ps
// Behaviour
// - Queue is 4K 32-bit words, indexed
// - Entry names line, channel, statistic index
// - Bit 15 flags further entries remain
// - Sixteen timers, two groups of eight
// - Select top bit 0 is group b
// - Run bit writable, cleared at zero
// - Decrement every 12x512 clocks while running
// - Count stops at 7fff, sets status
// - Group enable low disables its timers
// - Insertion buffer one cell, header first
// - Header word packs VCI, PTI, CLP, VPI fields
// - Extraction 254 cells, index plus two
// - Segmentation region line/chan/cell/word addressed
// - Software programs transmit header at cell0
// - Software avoids other segmentation words
// - Reassembly region eight cells per channel
// - Software need not touch device buffers
// - RAM has no reset, software initialises
// - At most one queue entry per counter
// - Threshold above saturation never queues
module srmq_device #(
  parameter int IQ_DEPTH   = 4096,
  parameter int TICK_COUNT = srmq_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  srmq_if.device           bus,
  // Statistic threshold events from the counter engine
  input  wire logic        stat_event,
  input  wire logic [2:0]  line_index,
  input  wire logic [4:0]  slot_channel_index,
  input  wire logic [3:0]  statistic_index,
  input  wire logic [31:0] stat_value,
  input  wire logic [30:0] stat_threshold,
  input  wire logic        stat_threshold_on,
  input  wire logic        stat_already_queued,
  output logic             stat_mark_queued,
  input  wire logic        countdown_group_a_enable,
  input  wire logic        countdown_group_b_enable,
  output logic [7:0]       irq_status_one,
  output logic [7:0]       irq_status_two
);
  // Only a 4K queue and a divider of two or more clocks can be served
  if (IQ_DEPTH != 4096 || TICK_COUNT < 2)
  begin : g_bad_params
    $error("srmq_device: unsupported parameters");
  end

  // Device RAM; no reset, software initialises it
  logic [31:0] iq_mem   [0:4095];
  logic [31:0] misc_mem [0:4095];
  logic [31:0] buf_mem  [0:49151];
  logic [31:0] timer    [0:15];

  logic [17:0] a;
  assign a = bus.host_byte_address;
  logic [15:0] ram_word_address;
  assign ram_word_address = a[16:1];
  logic hi_half;
  assign hi_half = a[0];

  // Region decode
  wire is_iq  = a[17:13] == srmq_pkg::IQ_REGION;
  wire is_msc = a[17:13] == srmq_pkg::MISC_REGION;
  wire is_tmr = is_msc && a[12:0] < srmq_pkg::TIMER_END;
  wire is_seg = a[17:15] == srmq_pkg::SEG_REGION;
  wire is_ras = a[17:16] == srmq_pkg::RAS_REGION;
  wire [3:0] countdown_select = a[4:1];
  wire [11:0] iq_idx = a[12:1];
  // Misc index: insertion words at 16..31, extraction cells from index 2
  wire [11:0] misc_idx = a[12:1];
  // Buffer index: seg 0..16383, reassembly 16384..49151
  wire [15:0] buf_idx = is_ras ? 16'(16'h4000 + {1'b0, a[15:1]}) : {2'b00, a[14:1]};

  // Queue write pointer and count; the host reads head entries
  logic [11:0] iq_wr;
  logic [12:0] iq_cnt;
  wire threshold_hit = stat_threshold_on && !stat_already_queued
    && {1'b0, stat_threshold} <= srmq_pkg::STAT_SAT
    && stat_value >= {1'b0, stat_threshold};
  wire iq_push = stat_event && threshold_hit && iq_cnt < 13'(IQ_DEPTH);
  wire iq_pop = bus.rd && is_iq && !hi_half && iq_cnt != 13'h0000;
  wire [31:0] iq_entry = {16'h0000, 1'b1, 3'b000, line_index, slot_channel_index,
                          statistic_index};

  // Queue head read: more-flag reflects remaining entries
  wire [31:0] iq_head = {iq_mem[iq_idx][31:16],
    iq_cnt > 13'h0001, iq_mem[iq_idx][14:0]};

  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (is_iq) rd_word = iq_head;
    else if (is_tmr) rd_word = timer[countdown_select];
    else if (is_msc) rd_word = misc_mem[misc_idx];
    else if (is_seg || is_ras) rd_word = buf_mem[buf_idx];
  end
  wire [15:0] rd_half = hi_half ? rd_word[31:16] : rd_word[15:0];

  // Bus response: one-cycle ack with registered data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus.ack   <= 1'b0;
      bus.rdata <= 16'h0000;
    end
    else
    begin
      bus.ack <= (bus.rd || bus.wr) && !bus.ack;
      // Taken once per read, so the pop that follows cannot alter it
      if (bus.rd && !bus.ack) bus.rdata <= rd_half;
    end
  end

  // Host writes into RAM by halves
  always_ff @(posedge clk)
  begin
    if (bus.wr && !bus.ack)
    begin
      if (is_iq)
        if (hi_half) iq_mem[iq_idx][31:16] <= bus.wdata;
        else iq_mem[iq_idx][15:0] <= bus.wdata;
      else if (is_msc && !is_tmr)
        if (hi_half) misc_mem[misc_idx][31:16] <= bus.wdata;
        else misc_mem[misc_idx][15:0] <= bus.wdata;
      else if (is_seg || is_ras)
        if (hi_half) buf_mem[buf_idx][31:16] <= bus.wdata;
        else buf_mem[buf_idx][15:0] <= bus.wdata;
    end
    if (iq_push) iq_mem[iq_wr] <= iq_entry;
  end

  // Queue pointers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      iq_wr <= 12'h000;
      iq_cnt <= 13'h0000;
      stat_mark_queued <= 1'b0;
    end
    else
    begin
      if (iq_push) iq_wr <= iq_wr + 12'h001;
      iq_cnt <= iq_cnt + 13'(iq_push) - 13'(iq_pop && !bus.ack);
      stat_mark_queued <= iq_push;
    end
  end

  // Tick divider shared by all timers; trades per-timer phase for area
  logic [$clog2(TICK_COUNT)-1:0] tick_cnt;
  wire tick = tick_cnt == '0;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n) tick_cnt <= '0;
    else if (tick) tick_cnt <= ($clog2(TICK_COUNT))'(TICK_COUNT - 1);
    else tick_cnt <= tick_cnt - 1'b1;
  end

  // Timers: host write wins over count; status set when stop value hit
  logic [7:0] next_st_one;
  logic [7:0] next_st_two;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_status_one <= 8'h00;
      irq_status_two <= 8'h00;
    end
    else
    begin
      irq_status_one <= next_st_one;
      irq_status_two <= next_st_two;
    end
  end

  always_comb
  begin
    next_st_one = irq_status_one;
    next_st_two = irq_status_two;
    for (int i = 0; i < 16; i++)
      if (timer[i][srmq_pkg::TM_CNT_W-1:0] == srmq_pkg::TM_STOP)
        if (i >= 8) next_st_one[i-8] = 1'b1;
        else next_st_two[i] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (bus.wr && !bus.ack && is_tmr && countdown_select == 4'(i))
        if (hi_half) timer[i][31:16] <= bus.wdata;
        else timer[i][15:0] <= bus.wdata;
      else if (timer[i][srmq_pkg::TM_RUN] && tick
               && (i >= 8 ? countdown_group_a_enable : countdown_group_b_enable))
      begin
        if (timer[i][14:0] == srmq_pkg::TM_ZERO)
          timer[i][srmq_pkg::TM_RUN] <= 1'b0;
        else if (timer[i][14:0] != srmq_pkg::TM_STOP)
          timer[i][14:0] <= timer[i][14:0] - 15'h0001;
      end
    end
  end

  // Interrupt lines follow any set status bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus.host_irq_line_a <= 1'b0;
      bus.host_irq_line_b <= 1'b0;
    end
    else
    begin
      bus.host_irq_line_a <= |next_st_one;
      bus.host_irq_line_b <= |next_st_two;
    end
  end
endmodule : srmq_device

// ---- common/srmq_pkg.sv ----
package srmq_pkg;
  // Host bus widths: 18-bit byte address, 16-bit half-word data
  localparam int HADDR_W = 18;
  localparam int HDATA_W = 16;
  localparam int WORD_W  = 32;

  // Region bases, compared on host_byte_address[17:13] or coarser
  localparam logic [4:0] IQ_REGION   = 5'h12;  // 24000..25fff
  localparam logic [4:0] MISC_REGION = 5'h13;  // 26000..27fff
  localparam logic [2:0] SEG_REGION  = 3'h5;   // 28000..2ffff
  localparam logic [1:0] RAS_REGION  = 2'h3;   // 30000..3ffff
  // Within 26000..27fff: timers below 26020, insertion below 26040
  localparam logic [12:0] TIMER_END  = 13'h0020;
  localparam logic [12:0] INSERT_END = 13'h0040;

  // Queue entry fields
  localparam int QE_MORE     = 15;
  localparam int QE_LINE_LSB = 9;
  localparam int QE_CHAN_LSB = 4;

  // Timer word fields: run bit on top, 15-bit count below
  localparam int TM_RUN = 31;
  localparam int TM_CNT_W = 15;
  localparam logic [14:0] TM_STOP = 15'h7fff;
  localparam logic [14:0] TM_ZERO = 15'h0000;

  // Decrement tick: 12 x 512 core clocks
  localparam int TICK_MUL = 12;
  localparam int TICK_DIV = 512;
  localparam int TICK_CYCLES = TICK_MUL * TICK_DIV;

  // Statistics counter saturation value
  localparam logic [31:0] STAT_SAT = 32'h4000_0000;

  // Host access states
  typedef enum logic [1:0] {
    SRMQ_IDLE  = 2'b00,
    SRMQ_READ  = 2'b01,
    SRMQ_WRITE = 2'b10
  } srmq_state_t;
endpackage : srmq_pkg

// ---- common/srmq_if.sv ----
`timescale 1ns/1ps
interface srmq_if;
  logic [17:0] host_byte_address;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rd;
  logic        wr;
  logic        ack;
  logic        host_irq_line_a;
  logic        host_irq_line_b;

  modport device (
    input  host_byte_address, wdata, rd, wr,
    output rdata, ack, host_irq_line_a, host_irq_line_b
  );
  modport host (
    output host_byte_address, wdata, rd, wr,
    input  rdata, ack, host_irq_line_a, host_irq_line_b
  );
endinterface : srmq_if

// ---- src/srmq_host.sv ----
`timescale 1ns/1ps
// Host end: performs single 16-bit accesses on request
module srmq_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  srmq_if.host             bus,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [17:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             done,
  output logic [15:0]      done_rdata,
  output logic             irq_a,
  output logic             irq_b
);
  srmq_pkg::srmq_state_t state;
  srmq_pkg::srmq_state_t next_state;

  // Segmentation words other than a header are refused
  wire seg_hdr = req_addr[17:15] == srmq_pkg::SEG_REGION && req_addr[6:0] == 7'h00;
  wire seg_bad = req_addr[17:15] == srmq_pkg::SEG_REGION && req_addr[6:1] != 6'h00;
  // Device buffers are left alone
  wire ras_bad = req_addr[17:16] == srmq_pkg::RAS_REGION;
  wire legal = !(seg_bad || ras_bad) || seg_hdr;

  always_comb
  begin
    next_state = state;
    case (state)
      srmq_pkg::SRMQ_IDLE:
        if (req && legal) next_state = req_write ? srmq_pkg::SRMQ_WRITE : srmq_pkg::SRMQ_READ;
      default:
        if (bus.ack) next_state = srmq_pkg::SRMQ_IDLE;
    endcase
  end

  // Strobes held until the device acknowledges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= srmq_pkg::SRMQ_IDLE;
      bus.rd <= 1'b0;
      bus.wr <= 1'b0;
      bus.host_byte_address <= 18'h00000;
      bus.wdata <= 16'h0000;
      done <= 1'b0;
      done_rdata <= 16'h0000;
      irq_a <= 1'b0;
      irq_b <= 1'b0;
    end
    else
    begin
      state <= next_state;
      irq_a <= bus.host_irq_line_a;
      irq_b <= bus.host_irq_line_b;
      done <= (state != srmq_pkg::SRMQ_IDLE) && bus.ack;
      if (state == srmq_pkg::SRMQ_READ && bus.ack) done_rdata <= bus.rdata;
      if (state == srmq_pkg::SRMQ_IDLE && req && legal)
      begin
        bus.host_byte_address <= req_addr;
        bus.wdata <= req_wdata;
        bus.rd <= !req_write;
        bus.wr <= req_write;
      end
      else if (bus.ack)
      begin
        bus.rd <= 1'b0;
        bus.wr <= 1'b0;
      end
    end
  end
endmodule : srmq_host

// ---- dv/srmq_chk.sv ----
`timescale 1ns/1ps
// Watches the host bus between the two ends
module srmq_chk (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [17:0] host_byte_address,
  input wire logic [15:0] rdata,
  input wire logic        rd,
  input wire logic        wr,
  input wire logic        ack
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Handshake steps: open strobe, then answer and release
  sequence s_req;
    (rd || wr) && !ack;
  endsequence
  sequence s_done;
    ack ##1 !(rd || wr);
  endsequence

  // Handshake timing and holding
  ack_follows_req_a: assert property (s_req |=> ack) else $error("ack late");
  ack_one_cycle_a: assert property (ack |=> !ack) else $error("ack too long");
  ack_has_cause_a: assert property (ack |-> (rd || wr)) else $error("stray ack");
  strobe_release_a: assert property (s_req |=> s_done) else $error("no release");
  one_strobe_a: assert property (!(rd && wr)) else $error("rd and wr");
  addr_hold_a: assert property (s_req |=> $stable(host_byte_address)) else $error("addr moved");
  rdata_hold_a: assert property (!ack |-> $stable(rdata)) else $error("rdata moved");
  // Places software keeps away from; the device owns them
  no_reassembly_a: assert property ((rd || wr) |-> host_byte_address[17:16] != 2'h3)
    else $error("reassembly access");
  seg_header_only_a: assert property
    ((rd || wr) && host_byte_address[17:15] == 3'h5 |-> host_byte_address[6:1] == 6'h00)
    else $error("segmentation access");
endmodule : srmq_chk

// ---- dv/shared_ram_map_queue_timers_test.sv ----
`timescale 1ns/1ps
module shared_ram_map_queue_timers_test;
  logic        clk, reset_n, req, req_write, done, irq_a, irq_b;
  logic        stat_event, stat_mark_queued, stat_already_queued, ga_en, gb_en, thr_on;
  logic [17:0] req_addr;
  logic [15:0] req_wdata, done_rdata, rd_val;
  logic [2:0]  line_index;
  logic [4:0]  slot_channel_index;
  logic [3:0]  statistic_index;
  logic [31:0] stat_value;
  logic [30:0] stat_threshold;
  logic [7:0]  irq_status_one, irq_status_two;
  int          n_mismatch, check_count, cycles;

  srmq_if srmq_if_i ();
  // Short tick so countdowns finish quickly
  srmq_device #(.IQ_DEPTH(4096), .TICK_COUNT(4)) srmq_device_i (
    .clk(clk), .reset_n(reset_n), .bus(srmq_if_i.device), .stat_event(stat_event),
    .line_index(line_index), .slot_channel_index(slot_channel_index),
    .statistic_index(statistic_index), .stat_value(stat_value),
    .stat_threshold(stat_threshold), .stat_threshold_on(thr_on),
    .stat_already_queued(stat_already_queued), .stat_mark_queued(stat_mark_queued),
    .countdown_group_a_enable(ga_en), .countdown_group_b_enable(gb_en),
    .irq_status_one(irq_status_one), .irq_status_two(irq_status_two));
  srmq_host srmq_host_i (
    .clk(clk), .reset_n(reset_n), .bus(srmq_if_i.host), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .done_rdata(done_rdata),
    .irq_a(irq_a), .irq_b(irq_b));
  srmq_chk srmq_chk_i (
    .clk(clk), .reset_n(reset_n), .host_byte_address(srmq_if_i.host_byte_address),
    .rdata(srmq_if_i.rdata), .rd(srmq_if_i.rd), .wr(srmq_if_i.wr), .ack(srmq_if_i.ack));

  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check_word(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check_word

  task automatic check_flag(input logic exp, input logic got);
    check_word({15'h0, exp}, {15'h0, got});
  endtask : check_flag

  // One request; done may take a few cycles, so the wait is bounded
  task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d);
    int n;
    @(negedge clk);
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    rd_val = done_rdata;
    check_flag(1'b1, done);
  endtask : access

  // Low half first, so a run bit in the high half starts a timer last
  task automatic write32(input logic [17:0] a, input logic [31:0] v);
    access(1'b1, a, v[15:0]);
    access(1'b1, a | 18'h1, v[31:16]);
  endtask : write32

  task automatic read_check(input logic [17:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0);
    check_word(exp, rd_val);
  endtask : read_check

  // A refused request gives no sign at all, so only silence is checked
  task automatic refused(input logic [17:0] a);
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    req = 1'b1;
    req_write = 1'b1;
    req_addr = a;
    @(negedge clk);
    req = 1'b0;
    repeat (6)
    begin
      @(negedge clk);
      seen = seen | done;
    end
    check_flag(1'b0, seen);
  endtask : refused

  task automatic test_buffers();
    logic [17:0] ad [4] = '{18'h26020, 18'h2603e, 18'h27ffe, 18'h2b280};
    foreach (ad[i]) write32(ad[i], {ad[i][15:0], ~ad[i][15:0]});
    foreach (ad[i])
    begin
      read_check(ad[i], ~ad[i][15:0]);
      read_check(ad[i] | 18'h1, ad[i][15:0]);
    end
    refused(18'h2b282);
    refused(18'h30000);
  endtask : test_buffers

  task automatic test_timers();
    for (int t = 0; t < 16; t++) write32(18'h26000 + 18'(2 * t), 32'h0);
    gb_en = 1'b0;
    write32(18'h26004, 32'h8000_0001);
    write32(18'h26002, 32'h8000_7fff);
    write32(18'h26010, 32'h8000_0003);
    read_check(18'h26011, 16'h8000);
    repeat (40) @(negedge clk);
    read_check(18'h26011, 16'h0000);
    read_check(18'h26005, 16'h8000);
    read_check(18'h26004, 16'h0001);
    check_word(16'h0002, {8'h0, irq_status_two});
    check_flag(1'b1, irq_b);
    check_word(16'h0000, {8'h0, irq_status_one});
    check_flag(1'b0, irq_a);
    write32(18'h26012, 32'h8000_7fff);
    repeat (8) @(negedge clk);
    read_check(18'h26012, 16'h7fff);
    check_word(16'h0002, {8'h0, irq_status_one});
    check_flag(1'b1, irq_a);
    gb_en = 1'b1;
  endtask : test_timers

  // One threshold event; expect a mark pulse or none
  task automatic event_in(input logic [11:0] id, input logic [31:0] v,
                          input logic [30:0] th, input logic q, input logic exp);
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    {line_index, slot_channel_index, statistic_index} = id;
    stat_value = v;
    stat_threshold = th;
    stat_already_queued = q;
    stat_event = 1'b1;
    @(negedge clk);
    stat_event = 1'b0;
    repeat (4)
    begin
      seen = seen | stat_mark_queued;
      @(negedge clk);
    end
    check_flag(exp, seen);
  endtask : event_in

  task automatic test_queue();
    event_in({3'h5, 5'h1a, 4'hc}, 32'd100, 31'd10, 1'b0, 1'b1);
    event_in({3'h2, 5'h03, 4'h1}, 32'd100, 31'd10, 1'b1, 1'b0);
    event_in({3'h1, 5'h1f, 4'hf}, 32'h4000_0000, 31'h4000_0001, 1'b0, 1'b0);
    event_in({3'h7, 5'h00, 4'h3}, 32'd100, 31'd10, 1'b0, 1'b1);
    thr_on = 1'b0;
    event_in({3'h3, 5'h05, 4'h2}, 32'd100, 31'd10, 1'b0, 1'b0);
    thr_on = 1'b1;
    read_check(18'h24000, {1'b1, 3'h0, 3'h5, 5'h1a, 4'hc});
    read_check(18'h24002, {1'b0, 3'h0, 3'h7, 5'h00, 4'h3});
  endtask : test_queue

  // Main sequence
  initial
  begin
    {reset_n, req, req_write, stat_event, stat_already_queued} = 5'h0;
    {req_addr, req_wdata, line_index, slot_channel_index, statistic_index} = '0;
    {stat_value, stat_threshold, ga_en, gb_en, thr_on} = {63'h0, 3'h7};
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    test_buffers();
    test_timers();
    test_queue();
    tally_and_finish();
  end
endmodule : shared_ram_map_queue_timers_test
